// [verilog/gpio_function_output_mux.sv]
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
module gpio_function_output_mux
  import pin_mux_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        pin2_clock_output,
  input  wire logic        pin3_clock_output,
  input  wire logic        serial_audio_out,
  input  wire logic        irq,
  input  wire logic        thermal_shutdown,
  input  wire logic        second_phase_loop_lock,
  input  wire logic        third_phase_loop_lock,
  input  wire logic        frequency_locked_loop_lock,
  input  wire logic        dynamic_range_controller_activity,
  input  wire logic        write_sequencer_done,
  input  wire logic        automatic_level_control_noise_gate,
  input  wire logic        automatic_level_control_peak_overload,
  input  wire logic        automatic_level_control_saturation,
  input  wire logic        automatic_level_control_threshold,
  input  wire logic        automatic_level_control_level_lock,
  input  wire logic        fifo_error,
  input  wire logic        auxiliary_output_clock,
  input  wire logic        dmic_output_clock,
  input  wire logic        mic_detect,
  input  wire logic        mic_short,
  output logic             pin2_out,
  output logic             pin3_out
);

  // ------------------------------------------------------------
  // Bus address phase decode
  // ------------------------------------------------------------
  // Only NONSEQ/SEQ transfers act; writes must also be whole-word, reads may be any size
  wire logic       bus_take   = hsel & hready & htrans[1];
  wire logic       word_size  = (hsize == HSIZE_WORD);
  wire logic       hit_pin2   = (haddr == PIN2_ADDR);
  wire logic       hit_pin3   = (haddr == PIN3_ADDR);
  wire logic [1:0] addr_hit   = {hit_pin3, hit_pin2};
  wire logic       take_write = bus_take & hwrite & word_size;
  wire logic       take_read  = bus_take & ~hwrite;

  logic [1:0] wr_sel_q;
  logic [1:0] wr_sel_d;
  logic       rd_phase_q;

  assign wr_sel_d = take_write ? addr_hit : 2'b00;

  // Data phase bookkeeping
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_sel_q   <= 2'b00;
      rd_phase_q <= 1'b0;
    end else begin
      wr_sel_q   <= wr_sel_d;
      rd_phase_q <= take_read;
    end
  end

  // ------------------------------------------------------------
  // Function control registers, index 0 is pin 2, index 1 is pin 3
  // ------------------------------------------------------------
  logic [4:0] fn_q  [NUM_PINS];
  logic [4:0] fn_d  [NUM_PINS];
  logic       inv_q [NUM_PINS];
  logic       inv_d [NUM_PINS];
  logic       lvl_q [NUM_PINS];
  logic       lvl_d [NUM_PINS];
  logic [31:0] src  [NUM_PINS];
  logic [31:0] common_src;
  logic        pin_out_w [NUM_PINS];

  pin_sel_if ps [NUM_PINS] (.hclk(hclk), .hresetn(hresetn));

  // Sources shared by both pins; reserved codes stay at zero
  always_comb begin
    common_src                = 32'h0000_0000;
    common_src[FN_SERIAL_OUT] = serial_audio_out;
    common_src[FN_IRQ]        = irq;
    common_src[FN_THERMAL]    = thermal_shutdown;
    common_src[FN_LOOP2_LOCK] = second_phase_loop_lock;
    common_src[FN_LOOP3_LOCK] = third_phase_loop_lock;
    common_src[FN_FREQ_LOCK]  = frequency_locked_loop_lock;
    common_src[FN_RANGE_BUSY] = dynamic_range_controller_activity;
    common_src[FN_SEQ_DONE]   = write_sequencer_done;
    common_src[FN_NOISE_GATE] = automatic_level_control_noise_gate;
    common_src[FN_PEAK_LIMIT] = automatic_level_control_peak_overload;
    common_src[FN_SATURATION] = automatic_level_control_saturation;
    common_src[FN_THRESHOLD]  = automatic_level_control_threshold;
    common_src[FN_LEVEL_LOCK] = automatic_level_control_level_lock;
    common_src[FN_FIFO_ERROR] = fifo_error;
    common_src[FN_AUX_CLOCK]  = auxiliary_output_clock;
    common_src[FN_DMIC_CLOCK] = dmic_output_clock;
    common_src[FN_MIC_DETECT] = mic_detect;
    common_src[FN_MIC_SHORT]  = mic_short;
  end

  // Per-pin clock source and fixed level override the shared vector
  always_comb begin
    src[0]                 = common_src;
    src[0][FN_CLOCK_OUT]   = pin2_clock_output;
    src[0][FN_FIXED_LEVEL] = lvl_q[0];
    src[1]                 = common_src;
    src[1][FN_CLOCK_OUT]   = pin3_clock_output;
    src[1][FN_FIXED_LEVEL] = lvl_q[1];
  end

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      // Same field layout on both pins
      assign fn_d[g]  = wr_sel_q[g] ? hwdata[FUNC_LSB +: FUNC_W]
                                    : fn_q[g];
      assign inv_d[g] = wr_sel_q[g] ? hwdata[INVERT_BIT] : inv_q[g];
      assign lvl_d[g] = wr_sel_q[g] ? hwdata[LEVEL_BIT] : lvl_q[g];

      // Field storage with documented defaults
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          fn_q[g]  <= FUNC_RESET;
          inv_q[g] <= INVERT_RESET;
          lvl_q[g] <= LEVEL_RESET;
        end else begin
          fn_q[g]  <= fn_d[g];
          inv_q[g] <= inv_d[g];
          lvl_q[g] <= lvl_d[g];
        end
      end

      assign ps[g].function_select = fn_q[g];
      assign ps[g].invert          = inv_q[g];
      assign ps[g].sources         = src[g];
      assign pin_out_w[g]          = ps[g].pin_out;

      pin_output_select u_sel (
        .p (ps[g])
      );

      a_write_fn_field: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_sel_q[g] |=> fn_q[g] == $past(hwdata[4:0]))
        else $error("function select not written from bus");

      a_write_inv_field: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_sel_q[g] |=> inv_q[g] == $past(hwdata[10]))
        else $error("polarity bit not written from bus");

      a_hold_no_write: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !wr_sel_q[g] |=> $stable(fn_q[g]) && $stable(inv_q[g]))
        else $error("pin control changed without a write");
    end
  endgenerate

  assign pin2_out = pin_out_w[0];
  assign pin3_out = pin_out_w[1];

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  // Read value built from next state, so a read right after a write
  // returns the new contents. Level bit reads zero: it is write-only.
  logic [31:0] rd_word [NUM_PINS];
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      rd_word[i]                      = 32'h0000_0000;
      rd_word[i][FUNC_LSB +: FUNC_W]  = fn_d[i];
      rd_word[i][INVERT_BIT]          = inv_d[i];
    end
  end

  wire logic [31:0] rd_next = hit_pin2 ? rd_word[0] :
                              hit_pin3 ? rd_word[1] : 32'h0000_0000;

  logic [31:0] hrdata_q;
  // Read data staged for the data phase; unmapped reads give zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (take_read) begin
      hrdata_q <= rd_next;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = 1'b1; // Zero wait states, never stalls
  assign hresp     = HRESP_OKAY;

  // ------------------------------------------------------------
  // Checks on pin routing and readback
  // ------------------------------------------------------------
  a_reset_fn_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> fn_q[1] == FUNC_RESET && fn_q[0] == FUNC_RESET)
    else $error("function select not zero after reset");

  a_level_unread: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_phase_q |-> hrdata[9:5] == 5'h00 && hrdata[31:11] == 21'h0)
    else $error("write-only or reserved bits read non-zero");

  a_fixed_level: assert property (
    @(posedge hclk) disable iff (!hresetn)
    fn_q[1] == 5'h01 |-> pin3_out == (lvl_q[1] ^ inv_q[1]))
    else $error("fixed level not driven on third pin");

  a_clock_route: assert property (
    @(posedge hclk) disable iff (!hresetn)
    fn_q[1] == 5'h00 |-> pin3_out == (pin3_clock_output ^ inv_q[1]))
    else $error("third pin clock not routed");

  a_second_clock: assert property (
    @(posedge hclk) disable iff (!hresetn)
    fn_q[0] == 5'h00 |-> pin2_out == (pin2_clock_output ^ inv_q[0]))
    else $error("second pin clock not routed");

  a_irq_route: assert property (
    @(posedge hclk) disable iff (!hresetn)
    fn_q[0] == 5'h03 |-> pin2_out == (irq ^ inv_q[0]))
    else $error("interrupt not routed to second pin");

  a_freq_lock: assert property (
    @(posedge hclk) disable iff (!hresetn)
    fn_q[1] == 5'h09 |-> pin3_out == (frequency_locked_loop_lock ^ inv_q[1]))
    else $error("frequency loop lock not routed");

  a_seq_done: assert property (
    @(posedge hclk) disable iff (!hresetn)
    fn_q[1] == 5'h0B |-> pin3_out == (write_sequencer_done ^ inv_q[1]))
    else $error("sequencer done not routed");

  a_level_lock: assert property (
    @(posedge hclk) disable iff (!hresetn)
    fn_q[0] == FN_LEVEL_LOCK |->
      pin2_out == (automatic_level_control_level_lock ^ inv_q[0]))
    else $error("level lock not routed");

  a_aux_clock: assert property (
    @(posedge hclk) disable iff (!hresetn)
    fn_q[1] == 5'h12 |-> pin3_out == (auxiliary_output_clock ^ inv_q[1]))
    else $error("auxiliary clock not routed");

  a_mic_short: assert property (
    @(posedge hclk) disable iff (!hresetn)
    fn_q[1] == 5'h16 |-> pin3_out == (mic_short ^ inv_q[1]))
    else $error("microphone short flag not routed");

  a_reserved_low: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (fn_q[0] inside {5'h05, 5'h08, 5'h14} || fn_q[0] >= 5'h17)
      |-> pin2_out == inv_q[0])
    else $error("reserved code drives a source");

endmodule

// [verilog/pin_mux_pkg.sv]
package pin_mux_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [31:0] PIN2_INDEX = 32'h0000_0201;
  localparam logic [31:0] PIN3_INDEX = 32'h0000_0202;
  localparam logic [31:0] PIN2_ADDR  = PIN2_INDEX << 2;
  localparam logic [31:0] PIN3_ADDR  = PIN3_INDEX << 2;
  localparam int          NUM_PINS   = 2;

  // ------------------------------------------------------------
  // Field layout and reset values
  // ------------------------------------------------------------
  localparam int         INVERT_BIT    = 10;
  localparam int         LEVEL_BIT     = 6;
  localparam int         FUNC_LSB      = 0;
  localparam int         FUNC_W        = 5;
  localparam logic [4:0] FUNC_RESET    = 5'h00;
  localparam logic       INVERT_RESET  = 1'b0;
  localparam logic       LEVEL_RESET   = 1'b0;

  // ------------------------------------------------------------
  // Function codes
  // ------------------------------------------------------------
  localparam logic [4:0] FN_CLOCK_OUT   = 5'h00;
  localparam logic [4:0] FN_FIXED_LEVEL = 5'h01;
  localparam logic [4:0] FN_SERIAL_OUT  = 5'h02;
  localparam logic [4:0] FN_IRQ         = 5'h03;
  localparam logic [4:0] FN_THERMAL     = 5'h04;
  localparam logic [4:0] FN_LOOP2_LOCK  = 5'h06;
  localparam logic [4:0] FN_LOOP3_LOCK  = 5'h07;
  localparam logic [4:0] FN_FREQ_LOCK   = 5'h09;
  localparam logic [4:0] FN_RANGE_BUSY  = 5'h0A;
  localparam logic [4:0] FN_SEQ_DONE    = 5'h0B;
  localparam logic [4:0] FN_NOISE_GATE  = 5'h0C;
  localparam logic [4:0] FN_PEAK_LIMIT  = 5'h0D;
  localparam logic [4:0] FN_SATURATION  = 5'h0E;
  localparam logic [4:0] FN_THRESHOLD   = 5'h0F;
  localparam logic [4:0] FN_LEVEL_LOCK  = 5'h10;
  localparam logic [4:0] FN_FIFO_ERROR  = 5'h11;
  localparam logic [4:0] FN_AUX_CLOCK   = 5'h12;
  localparam logic [4:0] FN_DMIC_CLOCK  = 5'h13;
  localparam logic [4:0] FN_PIN3_SPARE  = 5'h14;
  localparam logic [4:0] FN_MIC_DETECT  = 5'h15;
  localparam logic [4:0] FN_MIC_SHORT   = 5'h16;

  // ------------------------------------------------------------
  // Bus encodings
  // ------------------------------------------------------------
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic       HRESP_OKAY = 1'b0;

endpackage

// [verilog/pin_sel_if.sv]
`timescale 1ns/1ps
// Per-pin selection bundle between the register block and one pin mux
interface pin_sel_if (
  input wire logic hclk,
  input wire logic hresetn
);
  logic [4:0]  function_select;
  logic        invert;
  logic [31:0] sources;
  logic        pin_out;

  modport ctrl (input pin_out, output function_select, output invert,
                output sources, input hclk, input hresetn);
  modport mux  (input function_select, input invert, input sources,
                output pin_out, input hclk, input hresetn);
endinterface

// [verilog/pin_output_select.sv]
`timescale 1ns/1ps
module pin_output_select
  import pin_mux_pkg::*;
(
  pin_sel_if.mux p
);

  // Source pick and polarity; kept combinational so clocks pass intact
  wire logic raw_level = p.sources[p.function_select];

  assign p.pin_out = raw_level ^ p.invert;

  // A polarity flip alone must flip the pin, whatever the picked source
  a_invert_toggles: assert property (
    @(posedge p.hclk) disable iff (!p.hresetn)
    $changed(p.invert) && $stable(p.sources) && $stable(p.function_select)
      |-> $changed(p.pin_out))
    else $error("pin level does not follow polarity");

endmodule

// [test/pin_board_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Board-side model: drives the internal sources, reads the pins
// ----------------------------------------------------------------
module pin_board_model
  import pin_mux_pkg::*;
(
  input  wire logic [4:0]  probe_code,
  input  wire logic        probe_val,
  input  wire logic        pin2_out,
  input  wire logic        pin3_out,
  output logic      [31:0] src,
  output logic      [1:0]  seen
);
  // Probed source at probe_val, all others at its inverse, so a pin that
  // picks the wrong source shows the wrong level
  always_comb begin
    src = {32{~probe_val}};
    src[probe_code] = probe_val;
  end

  // The board only reads the two pins
  assign seen = {pin3_out, pin2_out};
endmodule

// [test/tb.sv]
`timescale 1ns/1ps
module tb
  import pin_mux_pkg::*;
;
  logic [31:0] haddr, hwdata, hrdata, src, rd_q;
  logic [1:0]  htrans, seen;
  logic [2:0]  hsize;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        pin2_out, pin3_out, probe_val;
  logic [4:0]  probe_code;
  int          fails, checks;

  // ----------------------------------------------------------------
  // Design and board model
  // ----------------------------------------------------------------
  // Pin3's clock sits on src[20], a code reserved on both pins
  gpio_function_output_mux gpio_function_output_mux_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pin2_clock_output(src[0]),
    .pin3_clock_output(src[20]), .serial_audio_out(src[2]), .irq(src[3]),
    .thermal_shutdown(src[4]), .second_phase_loop_lock(src[6]),
    .third_phase_loop_lock(src[7]), .frequency_locked_loop_lock(src[9]),
    .dynamic_range_controller_activity(src[10]),
    .write_sequencer_done(src[11]),
    .automatic_level_control_noise_gate(src[12]),
    .automatic_level_control_peak_overload(src[13]),
    .automatic_level_control_saturation(src[14]),
    .automatic_level_control_threshold(src[15]),
    .automatic_level_control_level_lock(src[16]), .fifo_error(src[17]),
    .auxiliary_output_clock(src[18]), .dmic_output_clock(src[19]),
    .mic_detect(src[21]), .mic_short(src[22]),
    .pin2_out(pin2_out), .pin3_out(pin3_out));

  pin_board_model pin_board_model_i (
    .probe_code(probe_code), .probe_val(probe_val), .pin2_out(pin2_out),
    .pin3_out(pin3_out), .src(src), .seen(seen));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Address phase held until hready is seen high
  task automatic bus_addr(input logic [31:0] a, input logic w);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    hsize  <= HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus_addr(a, 1'b1);
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    bus_addr(a, 1'b0);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
    chk({31'h0, hresp}, {31'h0, HRESP_OKAY}, "response");
  endtask

  // Reserved codes drive a low level before the inverter
  function automatic logic exp_pin(input int c, input logic v,
                                   input logic i);
    return ((c inside {[0:4], [6:7], [9:19], [21:22]}) ? v : 1'b0) ^ i;
  endfunction

  // ----------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  // The sweep needs about 1800 cycles; this leaves ample margin
  initial begin
    #50000;
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    conclude;
  end

  initial begin
    hresetn    = 1'b0;
    hsel       = 1'b0;
    haddr      = 32'h0000_0000;
    htrans     = 2'b00;
    hwrite     = 1'b0;
    hsize      = HSIZE_WORD;
    hwdata     = 32'h0000_0000;
    probe_code = 5'h00;
    probe_val  = 1'b1;
    fails      = 0;
    checks     = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    // Both pins start on code zero and follow their own clock
    rd(PIN2_ADDR, rd_q);
    chk(rd_q, 32'h0000_0000, "pin2 reset");
    rd(PIN3_ADDR, rd_q);
    chk(rd_q, 32'h0000_0000, "pin3 reset");
    @(negedge hclk);
    chk({30'h0, seen}, 32'h0000_0001, "reset pins");
    $display("test reset done");
    // Every code, both levels, both polarities, reserved codes included
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 32; c++) begin
        for (int k = 0; k < 4; k++) begin
          @(posedge hclk);
          probe_code <= (p == 1 && c == 0) ? 5'h14 : c[4:0];
          probe_val  <= k[0];
          wr(p ? PIN3_ADDR : PIN2_ADDR,
             {21'h0, k[1], 3'h0, k[0], 1'b0, c[4:0]});
          @(negedge hclk);
          chk(seen[p], exp_pin(c, k[0], k[1]), "pin level");
          rd(p ? PIN3_ADDR : PIN2_ADDR, rd_q);
          chk(rd_q, {21'h0, k[1], 5'h0, c[4:0]}, "readback");
        end
      end
    end
    $display("test sweep done");
    // Spare bits, unmapped write and unmapped read
    wr(PIN2_ADDR, 32'hFFFF_FFFF);
    rd(PIN2_ADDR, rd_q);
    chk(rd_q, 32'h0000_041F, "spare bits");
    wr(32'h0000_080C, 32'h0000_0001);
    rd(32'h0000_080C, rd_q);
    chk(rd_q, 32'h0000_0000, "unmapped read");
    rd(PIN2_ADDR, rd_q);
    chk(rd_q, 32'h0000_041F, "unmapped write leaked");
    $display("test stray done");
    // Reset in mid-run must drop both pins back to code zero
    @(posedge hclk);
    hresetn    <= 1'b0;
    probe_code <= 5'h00;
    probe_val  <= 1'b1;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(PIN2_ADDR, rd_q);
    chk(rd_q, 32'h0000_0000, "pin2 mid reset");
    rd(PIN3_ADDR, rd_q);
    chk(rd_q, 32'h0000_0000, "pin3 mid reset");
    @(negedge hclk);
    chk({30'h0, seen}, 32'h0000_0001, "mid reset pins");
    $display("test mid reset done");
    conclude;
  end
endmodule
